// [rtl/uafe_pkg.sv]
// Purpose: constants for the enhanced serial port receive logic
// Assumes: 8-bit special function register bus inside the controller
// Notes: offsets are register-space byte addresses
package uafe_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] SERIAL_PORT_CONTROL_ADDR = 8'h98;
   localparam logic [7:0] SLAVE_ADDRESS_ADDR = 8'hA9;
   localparam logic [7:0] SLAVE_ADDRESS_MASK_ADDR = 8'hB9;
   localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] SERIAL_PORT_CONTROL_RESET = 8'h00;
   localparam logic [7:0] SLAVE_ADDRESS_RESET = 8'h00;
   localparam logic [7:0] SLAVE_ADDRESS_MASK_RESET = 8'h00;
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTL_BIT7 = 7;
   localparam int CTL_MODE1 = 6;
   localparam int CTL_MPAE = 5;
   localparam int CTL_REN = 4;
   localparam int CTL_RX9 = 2;
   localparam int CTL_RCF = 0;
   localparam int PWR_VIEW = 6;
   // ----------------------------------------
   // receiver timing
   // ----------------------------------------
   localparam logic [3:0] OVERSAMPLE = 4'hF; // 16 ticks per bit, last index
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_B = 4'h8;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam int FIFO_WIDTH = 9;
   localparam int FIFO_DEPTH = 8;
   typedef enum logic [1:0] {UAFE_IDLE, UAFE_START, UAFE_DATA, UAFE_STOP} uafe_state_t;
endpackage

// [rtl/uafe_fifo.sv]
// Purpose: small synchronous FIFO for received characters
// Assumes: one clock, active-low async reset
// Notes: full and empty are exact; no write when full
`timescale 1ns/1ps
module uafe_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;
   // ----------------------------------------
   // pointer arithmetic
   // ----------------------------------------
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   // storage has no reset so it maps to plain registers
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end
   a_fifo_no_overflow: assert property (@(posedge mclk) disable iff (!rst_b)
      count == (AW+1)'(DEPTH) |-> ##1 count == (AW+1)'(DEPTH) || $fell(count[AW]) || !count[AW])
      else $error("fifo count exceeded depth");
endmodule

// [rtl/uafe_top.sv]
// Purpose: enhanced serial receive path: framing error and address match
// Assumes: sfr_* bus from the cpu core, rx_tick is a 16x baud pulse on mclk
// Notes: transmit path lives elsewhere; this block owns the control view
// Contract
// (R1) missing stop bit sets the framing error flag; here only in modes 1, 2 and 3, never in mode 0
// (R2) control bit 7 is framing error when view select set, else mode bit 0
// (R3) framing error flag clears only by software writing zero
// (R4) good frames never clear a pending framing error
// (R5) address matching only while multiproc address enable is set
// (R6) modes 2 and 3: receive complete only on given or broadcast match
// (R7) in 9-bit modes only a ninth bit of one marks an address
// (R8) mode 1: receive complete needs valid stop bit and address match
// (R9) given address is slave address AND mask; mask zeros ignored
// (R10) broadcast is slave address OR mask; result zeros ignored
// (R11) mode 0 ignores multiproc address enable
// (R12) slave address and mask reset to all zeros
// (R13) stop bit checked by majority sample at stop sampling point
`timescale 1ns/1ps
module uafe_top (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic rx_tick,
   input wire logic rxd,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [8:0] rx_data
);
   logic [7:0] ctl, next_ctl;
   logic fe, next_fe;
   logic [7:0] slave_address, next_slave_address, smask, next_smask, pwr, next_pwr;
   logic rxd_s1, rxd_s2;
   uafe_pkg::uafe_state_t st, next_st;
   logic [3:0] tick_cnt, next_tick_cnt;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [8:0] shreg, next_shreg;
   logic [2:0] samp, next_samp;
   logic frame_done, stop_ok, accept, push;
   logic fifo_ready;
   logic [8:0] rx_word;
   logic [1:0] mode;
   logic [3:0] nbits;

   // majority of three samples around mid-bit
   function automatic logic maj3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // (R9) (R10) masked compare; a zero in care marks a don't-care position
   function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] a,
                                     input logic [7:0] m);
      logic [7:0] given_care;
      logic [7:0] bcast_care;
      given_care = m;
      bcast_care = a | m;
      return (((b ^ (a & m)) & given_care) == 8'h00) ||
             (((b ^ 8'hFF) & bcast_care) == 8'h00);
   endfunction

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   // rxd is asynchronous; only rxd_s2 feeds logic
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
      end else begin
         rxd_s1 <= rxd;
         rxd_s2 <= rxd_s1;
      end
   end

   // (R2) mode bit 0 is hidden while the frame error view is selected
   assign mode = {ctl[uafe_pkg::CTL_BIT7], ctl[uafe_pkg::CTL_MODE1]};
   // mode 0 is shift mode here received as 8 bits; modes 2/3 carry a ninth bit
   assign nbits = mode[1] ? 4'h9 : 4'h8;

   // ----------------------------------------
   // receiver
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_tick_cnt = tick_cnt;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_samp = samp;
      frame_done = 1'b0;
      if (rx_tick) begin
         next_tick_cnt = 4'(tick_cnt + 1'b1);
         if (tick_cnt == uafe_pkg::SAMPLE_A) next_samp[0] = rxd_s2;
         if (tick_cnt == uafe_pkg::SAMPLE_B) next_samp[1] = rxd_s2;
         if (tick_cnt == uafe_pkg::SAMPLE_C) next_samp[2] = rxd_s2;
         unique case (st)
            uafe_pkg::UAFE_IDLE: begin
               next_tick_cnt = 4'h0;
               if (!rxd_s2 && ctl[uafe_pkg::CTL_REN]) next_st = uafe_pkg::UAFE_START;
            end
            uafe_pkg::UAFE_START: begin
               if (tick_cnt == uafe_pkg::OVERSAMPLE) begin
                  // false start bit drops back to idle
                  next_st = maj3(samp) ? uafe_pkg::UAFE_IDLE : uafe_pkg::UAFE_DATA;
                  next_bit_cnt = 4'h0;
               end
            end
            uafe_pkg::UAFE_DATA: begin
               if (tick_cnt == uafe_pkg::OVERSAMPLE) begin
                  next_shreg = {maj3(samp), shreg[8:1]};
                  next_bit_cnt = 4'(bit_cnt + 1'b1);
                  if (4'(bit_cnt + 1'b1) == nbits) next_st = uafe_pkg::UAFE_STOP;
               end
            end
            uafe_pkg::UAFE_STOP: begin
               // (R13) decide at the stop sampling point, not at bit end
               if (tick_cnt == 4'(uafe_pkg::SAMPLE_C + 1'b1)) begin
                  frame_done = 1'b1;
                  next_st = uafe_pkg::UAFE_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st <= uafe_pkg::UAFE_IDLE;
         tick_cnt <= 4'h0;
         bit_cnt <= 4'h0;
         shreg <= 9'h000;
         samp <= 3'h7;
      end else begin
         st <= next_st;
         tick_cnt <= next_tick_cnt;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         samp <= next_samp;
      end
   end

   // ----------------------------------------
   // frame qualification
   // ----------------------------------------
   always_comb begin
      logic [7:0] byte_in;
      logic ninth;
      byte_in = mode[1] ? shreg[7:0] : shreg[8:1];
      ninth = shreg[8];
      // (R13) same majority sample as a data bit
      stop_ok = maj3(samp);
      accept = 1'b1;
      if (mode == 2'b00) begin
         // (R11) shift mode never filters
         accept = 1'b1;
      end else if (ctl[uafe_pkg::CTL_MPAE]) begin
         // (R5) (R6) (R7) (R8) filter only with address enable set
         if (mode[1]) begin
            accept = ninth && addr_hit(byte_in, slave_address, smask);
         end else begin
            accept = stop_ok && addr_hit(byte_in, slave_address, smask);
         end
      end
      push = frame_done && accept;
   end

   // queued word: ninth bit in modes 2/3, else the stop sample rides in bit 8
   assign rx_word = mode[1] ? shreg : {stop_ok, shreg[8:1]};

   // ----------------------------------------
   // register file
   // ----------------------------------------
   always_comb begin
      logic wr_ctl;
      wr_ctl = sfr_wr && (sfr_addr == uafe_pkg::SERIAL_PORT_CONTROL_ADDR);
      next_ctl = ctl;
      next_fe = fe;
      next_slave_address = slave_address;
      next_smask = smask;
      next_pwr = pwr;
      if (wr_ctl) begin
         next_ctl[6:0] = sfr_wdata[6:0];
         // (R2) bit 7 write lands in the selected view
         if (pwr[uafe_pkg::PWR_VIEW]) next_fe = sfr_wdata[uafe_pkg::CTL_BIT7];
         else next_ctl[uafe_pkg::CTL_BIT7] = sfr_wdata[uafe_pkg::CTL_BIT7];
      end
      if (sfr_wr && sfr_addr == uafe_pkg::SLAVE_ADDRESS_ADDR) next_slave_address = sfr_wdata;
      if (sfr_wr && sfr_addr == uafe_pkg::SLAVE_ADDRESS_MASK_ADDR) next_smask = sfr_wdata;
      if (sfr_wr && sfr_addr == uafe_pkg::POWER_CONTROL_ADDR) next_pwr = sfr_wdata;
      // (R1) (R3) (R4) hardware only sets; set beats a same-cycle clear
      if (frame_done && !stop_ok && mode != 2'b00) next_fe = 1'b1;
      if (frame_done && mode != 2'b00) next_ctl[uafe_pkg::CTL_RX9] = shreg[8] | !mode[1];
      // receive complete wins over a software clear in the same cycle
      if (push) next_ctl[uafe_pkg::CTL_RCF] = 1'b1;
   end

   // (R12) address and mask come up all zero
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctl <= uafe_pkg::SERIAL_PORT_CONTROL_RESET;
         fe <= 1'b0;
         slave_address <= uafe_pkg::SLAVE_ADDRESS_RESET;
         smask <= uafe_pkg::SLAVE_ADDRESS_MASK_RESET;
         pwr <= uafe_pkg::POWER_CONTROL_RESET;
      end else begin
         ctl <= next_ctl;
         fe <= next_fe;
         slave_address <= next_slave_address;
         smask <= next_smask;
         pwr <= next_pwr;
      end
   end

   // (R2) read mux with the bit 7 view
   always_comb begin
      unique case (sfr_addr)
         uafe_pkg::SERIAL_PORT_CONTROL_ADDR:
            sfr_rdata = {pwr[uafe_pkg::PWR_VIEW] ? fe : ctl[uafe_pkg::CTL_BIT7], ctl[6:0]};
         uafe_pkg::SLAVE_ADDRESS_ADDR: sfr_rdata = slave_address;
         uafe_pkg::SLAVE_ADDRESS_MASK_ADDR: sfr_rdata = smask;
         uafe_pkg::POWER_CONTROL_ADDR: sfr_rdata = pwr;
         default: sfr_rdata = 8'h00;
      endcase
   end

   // accepted characters queue here; a full queue drops the character
   uafe_fifo #(.WIDTH(uafe_pkg::FIFO_WIDTH), .DEPTH(uafe_pkg::FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(rx_word),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_fe_set_on_bad_stop: assert property (@(posedge mclk) disable iff (!rst_b) // (R1)
      frame_done && !stop_ok && mode != 2'b00 |=> fe) else $error("fe not set");
   a_fe_sticky_hw: assert property (@(posedge mclk) disable iff (!rst_b) // (R3)
      fe && !(sfr_wr && sfr_addr == uafe_pkg::SERIAL_PORT_CONTROL_ADDR) |=> fe)
      else $error("fe cleared without write");
   a_fe_good_frame: assert property (@(posedge mclk) disable iff (!rst_b) // (R4)
      fe && frame_done && stop_ok && !sfr_wr |=> fe) else $error("good frame cleared fe");
   a_view_read: assert property (@(posedge mclk) disable iff (!rst_b) // (R2)
      sfr_addr == uafe_pkg::SERIAL_PORT_CONTROL_ADDR && pwr[uafe_pkg::PWR_VIEW]
      |-> sfr_rdata[7] == fe) else $error("bit 7 view wrong");
   a_mode9_addr_only: assert property (@(posedge mclk) disable iff (!rst_b) // (R7)
      push && mode[1] && ctl[uafe_pkg::CTL_MPAE] |-> shreg[8]) else $error("data passed filter");
   a_mode1_stop: assert property (@(posedge mclk) disable iff (!rst_b) // (R8)
      push && mode == 2'b01 && ctl[uafe_pkg::CTL_MPAE] |-> stop_ok) else $error("bad stop passed");
   a_filter_off: assert property (@(posedge mclk) disable iff (!rst_b) // (R5)
      frame_done && !ctl[uafe_pkg::CTL_MPAE] |-> push) else $error("filter active when off");
   a_mode0_ignore: assert property (@(posedge mclk) disable iff (!rst_b) // (R11)
      frame_done && mode == 2'b00 |-> push) else $error("mode 0 filtered");
   a_rcf_set: assert property (@(posedge mclk) disable iff (!rst_b) // (R6)
      push |=> ctl[uafe_pkg::CTL_RCF]) else $error("receive flag not set");
   c_fe_event: cover property (@(posedge mclk) disable iff (!rst_b) $rose(fe));
   c_addr_match: cover property (@(posedge mclk) disable iff (!rst_b)
      push && ctl[uafe_pkg::CTL_MPAE]);
   c_addr_reject: cover property (@(posedge mclk) disable iff (!rst_b) frame_done && !push);
   c_fifo_drop: cover property (@(posedge mclk) disable iff (!rst_b) push && !fifo_ready);
endmodule

// [tb/uafe_line_model.sv]
// Purpose: remote serial sender on the receive line, plus the 16x tick
// Assumes: tick runs free, two mclk per tick; line idles high
// Notes: can send a frame with a missing stop bit on command
`timescale 1ns/1ps
module uafe_line_model (
   input wire logic mclk,
   input wire logic rst_b,
   output logic rxd,
   output logic rx_tick
);
   // ------------------------------------------------
   // baud tick and frame sender
   // ------------------------------------------------
   // free tick: the baud generator sits on-chip, so it never stops
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_tick <= 1'b0;
      end else begin
         rx_tick <= ~rx_tick;
      end
   end

   initial begin
      rxd = 1'b1;
   end

   // hold one bit for 16 ticks
   task automatic put_bit(input logic b);
      rxd <= b;
      repeat (16) @(posedge mclk iff rx_tick);
   endtask

   // lsb first; the ninth bit only goes out in the 9-bit modes
   task automatic send(input logic [8:0] w, input logic nine, input logic stop_ok);
      @(posedge mclk iff rx_tick);
      put_bit(1'b0);
      for (int i = 0; i < 8; i++) begin
         put_bit(w[i]);
      end
      // address frames carry a ninth bit of one
      if (nine) begin
         put_bit(w[8]);
      end
      // stop bit low models a broken frame
      put_bit(stop_ok);
      rxd <= 1'b1;
      repeat (16) @(posedge mclk iff rx_tick);
   endtask
endmodule

// [tb/test_uafe_top.sv]
// Purpose: self-checking bench for framing error and address match
// Assumes: registers reached by the sfr write strobe and async read
// Notes: mode bits 7:6, enable 5, receive enable 4, flag bit 0
`timescale 1ns/1ps
module test_uafe_top;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic rx_tick;
   logic rxd;
   logic rx_valid;
   logic rx_ready = 1'b0;
   logic [8:0] rx_data;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;

   uafe_top i_uafe_top (.mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rx_tick(rx_tick), .rxd(rxd),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
   uafe_line_model i_uafe_line_model (.mclk(mclk), .rst_b(rst_b), .rxd(rxd), .rx_tick(rx_tick));

   // ------------------------------------------------
   // clock, watchdog and shared tasks
   // ------------------------------------------------
   // 10 MHz clock
   always #50 mclk = ~mclk;

   // hang guard, well above the expected run of about 8k cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         $display("MISMATCH %0t watchdog expired", $time);
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask

   // masked register read compare
   task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge mclk);
      sfr_addr <= a;
      @(negedge mclk);
      tests_run++;
      if ((sfr_rdata & m) !== e) begin
         miscompares++;
         $display("MISMATCH %0t reg %h got %h want %h", $time, a, sfr_rdata & m, e);
      end
   endtask

   // head of the receive queue, valid and word together
   task automatic chk_data(input logic [8:0] e);
      tests_run++;
      if (rx_valid !== 1'b1 || rx_data !== e) begin
         miscompares++;
         $display("MISMATCH %0t rx_data %h valid %b want %h", $time, rx_data, rx_valid, e);
      end
   endtask

   task automatic frame(input logic [8:0] w, input logic nine, input logic ok);
      i_uafe_line_model.send(w, nine, ok);
      repeat (8) @(posedge mclk);
   endtask

   // count characters popped; expected count checked when asked
   task automatic drain(input int e, input logic judge);
      int n;
      n = 0;
      @(posedge mclk);
      rx_ready <= 1'b1;
      repeat (20) begin
         @(posedge mclk);
         if (rx_valid === 1'b1) n++;
      end
      rx_ready <= 1'b0;
      if (judge) begin
         tests_run++;
         if (n != e) begin
            miscompares++;
            $display("MISMATCH %0t drained %0d want %0d", $time, n, e);
         end
      end
   endtask

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_reset();
      chk(8'h98, 8'hFF, 8'h00);
      chk(8'hA9, 8'hFF, 8'h00);
      chk(8'hB9, 8'hFF, 8'h00);
      chk(8'h87, 8'hFF, 8'h00);
      chk(8'h55, 8'hFF, 8'h00);
   endtask

   task automatic t_framing();
      wr(8'h98, 8'h50);
      wr(8'h87, 8'h40);
      frame(9'h0A5, 1'b0, 1'b0);
      chk(8'h98, 8'h80, 8'h80);
      frame(9'h03C, 1'b0, 1'b1);
      chk(8'h98, 8'h80, 8'h80);
      repeat (50) @(posedge mclk);
      chk(8'h98, 8'h80, 8'h80);
      wr(8'h98, 8'h50);
      chk(8'h98, 8'h80, 8'h00);
      wr(8'h87, 8'h00);
      wr(8'h98, 8'hD0);
      chk(8'h98, 8'h80, 8'h80);
      wr(8'h87, 8'h40);
      chk(8'h98, 8'h80, 8'h00);
      wr(8'h87, 8'h00);
      wr(8'h98, 8'h50);
      chk(8'h98, 8'h80, 8'h00);
   endtask

   // given c0/fd is 1100_00x0, broadcast or is 1111_11x1
   task automatic t_nine();
      wr(8'hA9, 8'hC0);
      wr(8'hB9, 8'hFD);
      wr(8'h98, 8'hB0);
      frame(9'h1C2, 1'b1, 1'b1);
      chk(8'h98, 8'h01, 8'h01);
      wr(8'h98, 8'hB0);
      frame(9'h1C1, 1'b1, 1'b1);
      chk(8'h98, 8'h01, 8'h00);
      frame(9'h0C0, 1'b1, 1'b1);
      chk(8'h98, 8'h01, 8'h00);
      wr(8'h98, 8'hF0);
      frame(9'h1FD, 1'b1, 1'b1);
      chk(8'h98, 8'h01, 8'h01);
      wr(8'h98, 8'hF0);
      frame(9'h17D, 1'b1, 1'b1);
      chk(8'h98, 8'h01, 8'h00);
   endtask

   task automatic t_eight();
      wr(8'h98, 8'h70);
      frame(9'h0C0, 1'b0, 1'b0);
      chk(8'h98, 8'h01, 8'h00);
      frame(9'h033, 1'b0, 1'b1);
      chk(8'h98, 8'h01, 8'h00);
      frame(9'h0C0, 1'b0, 1'b1);
      chk(8'h98, 8'h01, 8'h01);
      drain(0, 1'b0);
      wr(8'h98, 8'h50);
      frame(9'h033, 1'b0, 1'b1);
      chk(8'h98, 8'h01, 8'h01);
      chk_data(9'h133);
      wr(8'h98, 8'h30);
      frame(9'h033, 1'b0, 1'b1);
      chk(8'h98, 8'h01, 8'h01);
   endtask

   // nine good frames while nobody reads: the ninth is dropped
   task automatic t_fill();
      drain(0, 1'b0);
      wr(8'h98, 8'h50);
      for (int i = 0; i < 9; i++) begin
         frame(9'h010 + 9'(i), 1'b0, 1'b1);
      end
      drain(8, 1'b1);
      drain(0, 1'b1);
   endtask

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_framing();
      t_nine();
      t_eight();
      t_fill();
      summarize();
   end
endmodule
